// ===== rtl/cfgio_bank.sv
// Ten-pad configurable digital I/O bank
//
// How it works
// - Each pad: input, output or alternate
// - Input pads read synchronised pad level
// - Output pads take writes, report driven level
// - Alternate pads 2, 5, 6, 7 follow internal function only
// - Alternate mode only where function exists
// - Pad 2 alternate drives jamming indication
// - Pad 4 alternate is transmit control input
// - Pad 5 alternate drives transmit monitor
// - Pad 6 alternate drives alarm indication
// - Pad 7 alternate drives buzzer tone
// - Monitor high while transmitter active
// - Pad 4 held low in alternate mode disables transmitter
`timescale 1ns/100ps
`include "cfgio_params.svh"
module cfgio_bank #(
    parameter int NUM_PADS = `CFGIO_NUM_PADS
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Pad pins, three signals per pad
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe_out,
    // Configuration from firmware side
    input wire logic mode_wr_in,
    input wire logic [3:0] mode_pad_in,
    input wire logic [1:0] mode_val_in,
    input wire logic level_wr_in,
    input wire logic [NUM_PADS-1:0] level_mask_in,
    input wire logic [NUM_PADS-1:0] level_val_in,
    // Internal alternate-function sources
    input wire logic jamming_detect_in,
    input wire logic tx_active_in,
    input wire logic alarm_in,
    input wire logic buzzer_tone_in,
    // Readback and function results
    output logic [NUM_PADS-1:0] read_data_out,
    output logic [NUM_PADS-1:0] is_output_out,
    output logic [NUM_PADS-1:0] is_alt_out,
    output logic mode_err_out,
    output logic tx_disable_out
);
    // Fixed pad map cannot grow or shrink; the alternate
    // functions sit at hard-wired positions in the bank
    if (NUM_PADS != `CFGIO_NUM_PADS) begin : g_bad_width
        $error("cfgio_bank: NUM_PADS must be 10");
    end

    // The four-bit pad index cannot address more than 16 pads
    if (NUM_PADS > 16) begin : g_bad_index
        $error("cfgio_bank: NUM_PADS exceeds pad index range");
    end

    // Pad map, bit N-1 carries pad N:
    //   bit 0  pad 1, plain
    //   bit 1  pad 2, alternate jamming_detect_output
    //   bit 2  pad 3, plain
    //   bit 3  pad 4, alternate transmit control input
    //   bit 4  pad 5, alternate transmit_activity_monitor
    //   bit 5  pad 6, alternate alarm indication
    //   bit 6  pad 7, alternate buzzer tone
    //   bit 7  pad 8, plain
    //   bit 8  pad 9, open drain, pulled up outside
    //   bit 9  pad 10, open drain, pulled up outside
    //
    // Latency seen from the firmware side:
    //   a mode or level write taken on edge 0 moves the state
    //   on edge 0; pins and the mode view follow on edge 1.
    //   A pin change needs two synchroniser edges and one
    //   readback edge before it shows on read_data_out.
    // Trade-off: every output is registered, so the bank
    // costs one extra cycle but never glitches a pin.

    localparam logic [NUM_PADS-1:0] ALT_MASK = `CFGIO_ALT_MASK
        | `CFGIO_ALT_MASK_JAM;
    localparam logic [NUM_PADS-1:0] OD_MASK = `CFGIO_OD_MASK;
    // Pad 4 alternate is an input: never driven
    localparam logic [NUM_PADS-1:0] ALT_TXCTL = 10'h008;

    // Synchronised pins and per-pad state
    logic [NUM_PADS-1:0] pad_sync;
    logic [NUM_PADS-1:0] out_q;
    logic [NUM_PADS-1:0] alt_q;
    logic [NUM_PADS-1:0] level_q;
    // Combinational drive decision, registered before the pins
    logic [NUM_PADS-1:0] alt_level;
    logic [NUM_PADS-1:0] drive_level;
    logic [NUM_PADS-1:0] drive_en;
    logic mode_ok;

    // Pins come from outside; two flops first
    // Reset value 0 matches pads 1-8 reading low
    cfgio_sync #(
        .WIDTH(NUM_PADS)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    // Legal mode request for the addressed pad
    // Indices beyond the bank and code 3 are never legal
    function automatic logic cfgio_mode_legal(input logic [3:0] pad,
        input logic [1:0] mode);
        logic ok;
        ok = 1'b0;
        if (pad < 4'(NUM_PADS)) begin
            unique case (mode)
                cfgio_pkg::CFGIO_MODE_INPUT: ok = 1'b1;
                cfgio_pkg::CFGIO_MODE_OUTPUT: ok = 1'b1;
                cfgio_pkg::CFGIO_MODE_ALT: ok = ALT_MASK[pad];
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : cfgio_mode_legal

    assign mode_ok = cfgio_mode_legal(mode_pad_in, mode_val_in);

    // Per-pad mode as two flags; illegal requests dropped
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_q <= '0;
            alt_q <= '0;
        end else if (mode_wr_in && mode_ok) begin
            out_q[mode_pad_in] <=
                (mode_val_in == cfgio_pkg::CFGIO_MODE_OUTPUT);
            alt_q[mode_pad_in] <=
                (mode_val_in == cfgio_pkg::CFGIO_MODE_ALT);
        end
    end

    // Flag a refused mode request for one cycle
    // Firmware must sample it on the edge after the write;
    // it is not sticky, so a missed pulse is lost
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_err_out <= 1'b0;
        end else begin
            mode_err_out <= mode_wr_in && !mode_ok;
        end
    end

    // Output levels; writes land only on output pads
    // Pads 9 and 10 reset high so they come up released
    // when later switched to output
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_q <= `CFGIO_LEVEL_RST;
        end else if (level_wr_in) begin
            level_q <= (level_q & ~(level_mask_in & out_q))
                | (level_val_in & level_mask_in & out_q);
        end
    end

    // Alternate sources; pad 4 is an input so drives nothing
    always_comb begin
        alt_level = '0;
        alt_level[`CFGIO_PAD_JAM] = jamming_detect_in;
        alt_level[`CFGIO_PAD_TXMON] = tx_active_in;
        alt_level[`CFGIO_PAD_ALARM] = alarm_in;
        alt_level[`CFGIO_PAD_BUZZ] = buzzer_tone_in;
    end

    // Level: internal source on alternate pads, else register
    always_comb begin
        drive_level = (alt_level & alt_q) | (level_q & ~alt_q);
    end

    // Enable: push-pull outputs and driven alternates; open
    // drain pads pull low only, so a high level releases them
    always_comb begin
        drive_en = (out_q & ~OD_MASK) | (alt_q & ~ALT_TXCTL);
        drive_en = drive_en | (out_q & OD_MASK & ~drive_level);
    end

    // Registered pad drive, released during reset
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pad_out <= '0;
            pad_oe_out <= '0;
        end else begin
            pad_out <= drive_level;
            pad_oe_out <= drive_en;
        end
    end

    // Readback: pin for inputs, driven value for outputs
    // Alternate pads read 0: their level belongs to the function
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_data_out <= '0;
            is_output_out <= '0;
            is_alt_out <= '0;
        end else begin
            read_data_out <= (pad_sync & ~out_q & ~alt_q)
                | (level_q & out_q);
            is_output_out <= out_q;
            is_alt_out <= alt_q;
        end
    end

    // Transmit inhibit while pad 4 is in alternate mode and pulled low
    // Limitation: a low pulse shorter than a clock may be missed
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_disable_out <= 1'b0;
        end else begin
            tx_disable_out <= alt_q[`CFGIO_PAD_TXCTL]
                && !pad_sync[`CFGIO_PAD_TXCTL];
        end
    end
endmodule : cfgio_bank

// ===== rtl/cfgio_params.svh
// Constants for the configurable pad bank
`ifndef CFGIO_PARAMS_SVH
`define CFGIO_PARAMS_SVH
`define CFGIO_NUM_PADS 10
`define CFGIO_PAD_JAM 1
`define CFGIO_PAD_TXCTL 3
`define CFGIO_PAD_TXMON 4
`define CFGIO_PAD_ALARM 5
`define CFGIO_PAD_BUZZ 6
`define CFGIO_ALT_MASK 10'h078
`define CFGIO_ALT_MASK_JAM 10'h002
`define CFGIO_OD_MASK 10'h300
`define CFGIO_MODE_RST 2'h0
`define CFGIO_LEVEL_RST 10'h300
`endif

// ===== rtl/cfgio_pkg.sv
// Types for the configurable pad bank
package cfgio_pkg;
    typedef enum logic [1:0] {
        CFGIO_MODE_INPUT = 2'b00,
        CFGIO_MODE_OUTPUT = 2'b01,
        CFGIO_MODE_ALT = 2'b10
    } cfgio_mode_type;
endpackage : cfgio_pkg

// ===== rtl/cfgio_sync.sv
// Two-flop synchroniser for pad inputs
`timescale 1ns/100ps
module cfgio_sync #(
    parameter int WIDTH = 10
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by second stage
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : cfgio_sync

// ===== verif/cfgio_bank_chk.sv
// Checker for the pad bank ports
`timescale 1ns/100ps
module cfgio_chk #(parameter int NUM_PADS = 10) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [NUM_PADS-1:0] pad_in,
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe_out,
    input wire logic mode_wr_in,
    input wire logic [1:0] mode_val_in,
    input wire logic tx_active_in,
    input wire logic [NUM_PADS-1:0] read_data_out,
    input wire logic [NUM_PADS-1:0] is_output_out,
    input wire logic [NUM_PADS-1:0] is_alt_out,
    input wire logic mode_err_out,
    input wire logic tx_disable_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    mode_excl_a: assert property
        ((is_output_out & is_alt_out) == 0) else $error("pad in two modes");
    out_drive_a: assert property
        (((~pad_oe_out | (pad_out ^ read_data_out)) & is_output_out
        & 10'h0ff) == 0) else $error("output pad readback");
    alt_pads_a: assert property ((is_alt_out & ~10'h07a) == 0)
        else $error("alternate on plain pad");
    err_mode_a: assert property (mode_wr_in && mode_val_in == 2'h3
        |=> mode_err_out) else $error("bad mode not refused");
    tx_monitor_a: assert property
        ((is_alt_out[4] && $stable(tx_active_in))[*3] |->
        pad_oe_out[4] && pad_out[4] == tx_active_in) else $error("monitor");
    txctl_hiz_a: assert property (is_alt_out[3] |-> !pad_oe_out[3])
        else $error("control pad driven");
    tx_disable_a: assert property
        ((is_alt_out[3] && !pad_in[3])[*4] |-> tx_disable_out)
        else $error("transmitter not disabled");
    open_drain_a: assert property
        ((pad_oe_out & pad_out & 10'h300) == 0)
        else $error("open drain driven high");
    cover property (mode_err_out);
    cover property (tx_disable_out);
    cover property (is_alt_out[4] && pad_out[4]);
endmodule : cfgio_chk
bind cfgio_bank cfgio_chk #(.NUM_PADS(NUM_PADS)) chk (.*);

// ===== verif/cfgio_bank_tb.sv
// Self-checking bench for the pad bank
`timescale 1ns/100ps
`include "cfgio_params.svh"
module cfgio_bank_tb;
    localparam logic [9:0] ALT = `CFGIO_ALT_MASK | `CFGIO_ALT_MASK_JAM;
    logic clk = 0, rst = 1, mw = 0, lw = 0, merr, txd;
    logic [3:0] mp = 0, src = 0;
    logic [1:0] mv = 0;
    logic [9:0] lm = 0, lv = 0, en = 0, val = 0, pin, po, poe, rd, iso, isa;
    int mismatches = 0, compares = 0;
    cfgio_bank uut (.ref_clk_in(clk), .rst_in(rst), .pad_in(pin),
        .pad_out(po), .pad_oe_out(poe), .mode_wr_in(mw), .mode_pad_in(mp),
        .mode_val_in(mv), .level_wr_in(lw), .level_mask_in(lm),
        .level_val_in(lv), .jamming_detect_in(src[0]),
        .tx_active_in(src[1]), .alarm_in(src[2]), .buzzer_tone_in(src[3]),
        .read_data_out(rd), .is_output_out(iso), .is_alt_out(isa),
        .mode_err_out(merr), .tx_disable_out(txd));
    cfgio_ext ext (.pin_drv_in(po), .pin_oe_in(poe), .ext_en_in(en),
        .ext_val_in(val), .pin_out(pin));
    task chk(string n, logic [9:0] s, logic [9:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // Mode write, refusal flag one edge later, effect one more
    task wm(logic [3:0] p, logic [1:0] v, logic e);
        @(posedge clk) {mw, mp, mv} <= {1'b1, p, v};
        @(posedge clk) mw <= 0;
        #1 chk("err", {9'h0, merr}, {9'h0, e});
        repeat (2) @(posedge clk);
        #1;
    endtask : wm
    task wl(logic [9:0] m, logic [9:0] v);
        @(posedge clk) {lw, lm, lv} <= {1'b1, m, v};
        @(posedge clk) lw <= 0;
        repeat (2) @(posedge clk);
        #1;
    endtask : wl
    task t_input;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {en, val} <= {10'h0ff, k ? 10'h05a : 10'h0a5};
            repeat (4) @(posedge clk);
            #1 chk("rd in", rd, k ? 10'h35a : 10'h3a5);
        end
        $display("input test done");
    endtask : t_input
    task t_output;
        wm(0, 1, 0);
        wm(9, 1, 0);
        wl(10'h3ff, 10'h155);
        wm(2, 1, 0);
        chk("oe", poe, 10'h205);
        chk("rd out", rd, 10'h15b);
        chk("iso", iso, 10'h205);
        wl(10'h200, 10'h200);
        chk("od", {8'h0, poe[9], pin[9]}, 10'h001);
        $display("output test done");
    endtask : t_output
    task t_alt;
        for (int p = 0; p < 11; p++) wm(4'(p), 2'h2, p > 9 || !ALT[p]);
        wm(7, 3, 1);
        chk("isa", isa, 10'h07a);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {src, val} <= {k ? 4'h0 : 4'hf, 10'(k * 8)};
            repeat (4) @(posedge clk);
            #1 chk("jam", 10'(po[1]), 10'(k == 0));
            chk("mon", 10'(po[4]), 10'(k == 0));
            chk("alarm", 10'(po[5]), 10'(k == 0));
            chk("buzz", 10'(po[6]), 10'(k == 0));
            chk("alt oe", poe & 10'h07a, 10'h072);
            chk("txd", {9'h0, txd}, {9'h0, k == 0});
            chk("alt rd", rd & isa, 10'h0);
        end
        $display("alternate test done");
    endtask : t_alt
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 chk("rst", poe | po | rd | iso | isa, 10'h0);
        chk("rst pin", pin & 10'h300 | 10'(txd), 10'h300);
        repeat (5) @(posedge clk);
        rst <= 0;
        t_input;
        t_output;
        t_alt;
        report_and_stop;
    end
    // Watchdog far beyond the roughly one hundred cycles of the tests
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
endmodule : cfgio_bank_tb

// ===== verif/cfgio_ext.sv
// Far-side logic and pulls on the pads
`timescale 1ns/100ps
module cfgio_ext (
    input wire logic [9:0] pin_drv_in,
    input wire logic [9:0] pin_oe_in,
    input wire logic [9:0] ext_en_in,
    input wire logic [9:0] ext_val_in,
    output logic [9:0] pin_out
);
    // Pulled pads float high; others show the inverse, never a stale value
    localparam logic [9:0] PULL = 10'h308;
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe_in[i]) pin_out[i] = pin_drv_in[i];
            else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
            else pin_out[i] = PULL[i] | ~pin_drv_in[i];
        end
    end
endmodule : cfgio_ext
